// *** pkg/rcm_pkg.sv ***
// ----------------------------------------------------------------
// Constants for the rate-of-change monitor
// ----------------------------------------------------------------
package rcm_pkg;
    // Register offsets
    localparam logic [7:0] RCM_ADDR_GAIN = 8'h3d;
    localparam logic [7:0] RCM_ADDR_CONFIG = 8'h3e;
    localparam logic [7:0] RCM_ADDR_STATUS = 8'h3f;
    localparam logic [7:0] RCM_ADDR_RES_HI_CH1 = 8'h40;
    localparam logic [7:0] RCM_ADDR_LIM_HI_CH1 = 8'h41;
    localparam logic [7:0] RCM_ADDR_LIM_LO_CH1 = 8'h42;
    localparam logic [7:0] RCM_ADDR_SMPL_CH1 = 8'h43;
    localparam logic [7:0] RCM_ADDR_RES_HI_CH2 = 8'h44;
    localparam logic [7:0] RCM_ADDR_RES_LO = 8'h45;
    localparam logic [7:0] RCM_ADDR_LIM_HI_CH2 = 8'h46;
    localparam logic [7:0] RCM_ADDR_LIM_LO_CH2 = 8'h47;
    localparam logic [7:0] RCM_ADDR_SMPL_CH2 = 8'h48;
    // Value of every register after reset
    localparam logic [7:0] RCM_RST_BYTE = 8'h00;
    // Configuration fields
    localparam int RCM_CFG_EN_BIT = 5;
    localparam int RCM_CFG_SUP2_BIT = 4;
    localparam int RCM_CFG_SUP1_BIT = 3;
    localparam int RCM_CFG_HYST_LSB = 0;
    localparam int RCM_CFG_WIDTH = 6;
    // Gain fields, three bits per channel
    localparam int RCM_GAIN_CH1_LSB = 0;
    localparam int RCM_GAIN_CH2_LSB = 3;
    // Status fields, channel 2 one bit above channel 1
    localparam int RCM_ST_LO_CH1 = 0;
    localparam int RCM_ST_HI_CH1 = 2;
    localparam int RCM_ST_PAR_CH1 = 4;
    localparam int RCM_ST_REV_CH1 = 6;
    // Low limit nibble position
    localparam int RCM_LIM_LO_LSB = 4;
    // Sample codes at or above this select the longest period
    localparam logic [3:0] RCM_SMPL_MAX_CODE = 4'h8;
    // Hysteresis per code in 0.125 degree steps
    localparam logic [5:0] RCM_HYST_STEPS [8] = '{6'h00, 6'h01, 6'h02,
        6'h04, 6'h08, 6'h10, 6'h18, 6'h20};
    // Channel sequencer states
    typedef enum logic {RCM_IDLE, RCM_RUN} rcm_state_type;
endpackage

// *** src/rcm_channel.sv ***
`timescale 1ns/1ps
// ----------------------------------------------------------------
// One channel: slope tracking, period count, scaled difference
// ----------------------------------------------------------------
module rcm_channel #(
    parameter int W = 12
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic enable,
    input wire logic sample_valid,
    input wire logic [W-1:0] sample_temp,
    input wire logic [2:0] gain_code,
    input wire logic [2:0] hyst_code,
    input wire logic [3:0] count_code,
    input wire logic [W-1:0] limit,
    output logic done,
    output logic [W-1:0] result,
    output logic reversed,
    output logic parity,
    output logic over_hi,
    output logic over_lo
);
    rcm_pkg::rcm_state_type state_q, state_d; // Sequencer
    logic [W-1:0] first_q, first_d; // First sample of period
    logic [W-1:0] ext_q, ext_d; // Extreme in current direction
    logic dir_q, dir_d; // One while falling
    logic dir_ok_q, dir_ok_d; // Direction known
    logic rev_q, rev_d, par_q, par_d; // Period reversal state
    logic [8:0] cnt_q, cnt_d; // Intervals taken
    logic done_d, reversed_d, parity_d, hi_d, lo_d;
    logic [W-1:0] result_d;
    logic [8:0] span; // Intervals per period
    logic signed [W:0] dev, tot, hs; // Deviation, total, hysteresis
    logic [W+7:0] scaled; // Difference after gain
    logic [W-1:0] sat; // Saturated result
    logic [W:0] mag; // Magnitude of result
    logic last; // This sample closes the period

    // ----------------------------------------------------------------
    // Next state
    // ----------------------------------------------------------------
    always_comb begin
        hs = $signed({{(W-5){1'b0}}, rcm_pkg::RCM_HYST_STEPS[hyst_code]});
        if (count_code >= rcm_pkg::RCM_SMPL_MAX_CODE) begin
            span = 9'h100;
        end else begin
            span = 9'h001 << count_code[2:0];
        end
        dev = $signed({sample_temp[W-1], sample_temp} - {ext_q[W-1], ext_q});
        tot = $signed({sample_temp[W-1], sample_temp} - {first_q[W-1], first_q});
        scaled = {{7{tot[W]}}, tot} << gain_code;
        // Clamp rather than wrap so a steep slope never reads as shallow
        if (!scaled[W+7] && (|scaled[W+6:W-1])) begin
            sat = {1'b0, {(W-1){1'b1}}};
        end else if (scaled[W+7] && !(&scaled[W+6:W-1])) begin
            sat = {1'b1, {(W-1){1'b0}}};
        end else begin
            sat = scaled[W-1:0];
        end
        mag = sat[W-1] ? (~{sat[W-1], sat}) + 1'b1 : {1'b0, sat};
        last = (cnt_q + 9'h001) == span;
        state_d = state_q;
        first_d = first_q;
        ext_d = ext_q;
        dir_d = dir_q;
        dir_ok_d = dir_ok_q;
        rev_d = rev_q;
        par_d = par_q;
        cnt_d = cnt_q;
        done_d = 1'b0;
        result_d = result;
        reversed_d = reversed;
        parity_d = parity;
        hi_d = over_hi;
        lo_d = over_lo;
        if (!enable) begin
            // Disabled: restart from a fresh first sample later
            state_d = rcm_pkg::RCM_IDLE;
            cnt_d = 9'h000;
            rev_d = 1'b0;
            par_d = 1'b0;
            dir_ok_d = 1'b0;
        end else if (sample_valid) begin
            case (state_q)
                rcm_pkg::RCM_IDLE: begin
                    state_d = rcm_pkg::RCM_RUN;
                    first_d = sample_temp;
                    ext_d = sample_temp;
                end
                rcm_pkg::RCM_RUN: begin
                    cnt_d = cnt_q + 9'h001;
                    if (!dir_ok_q) begin
                        // Direction set by first move past hysteresis
                        if (dev > hs || dev < -hs) begin
                            dir_ok_d = 1'b1;
                            dir_d = dev[W];
                            ext_d = sample_temp;
                        end
                    end else if (!dir_q ? dev > 0 : dev < 0) begin
                        ext_d = sample_temp;
                    end else if (!dir_q ? dev < -hs : dev > hs) begin
                        rev_d = 1'b1;
                        par_d = ~par_q;
                        dir_d = ~dir_q;
                        ext_d = sample_temp;
                    end
                    if (last) begin
                        done_d = 1'b1;
                        result_d = sat;
                        reversed_d = rev_d;
                        parity_d = par_d;
                        hi_d = !sat[W-1] && mag > {1'b0, limit};
                        lo_d = sat[W-1] && mag > {1'b0, limit};
                        first_d = sample_temp;
                        ext_d = sample_temp;
                        cnt_d = 9'h000;
                        rev_d = 1'b0;
                        par_d = 1'b0;
                        dir_ok_d = 1'b0;
                    end
                end
                default: state_d = rcm_pkg::RCM_IDLE;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // Registers
    // ----------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            state_q <= rcm_pkg::RCM_IDLE;
            first_q <= '0;
            ext_q <= '0;
            dir_q <= 1'b0;
            dir_ok_q <= 1'b0;
            rev_q <= 1'b0;
            par_q <= 1'b0;
            cnt_q <= 9'h000;
            done <= 1'b0;
            result <= '0;
            reversed <= 1'b0;
            parity <= 1'b0;
            over_hi <= 1'b0;
            over_lo <= 1'b0;
        end else begin
            state_q <= state_d;
            first_q <= first_d;
            ext_q <= ext_d;
            dir_q <= dir_d;
            dir_ok_q <= dir_ok_d;
            rev_q <= rev_d;
            par_q <= par_d;
            cnt_q <= cnt_d;
            done <= done_d;
            result <= result_d;
            reversed <= reversed_d;
            parity <= parity_d;
            over_hi <= hi_d;
            over_lo <= lo_d;
        end
    end

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    a_period_close: assert property (enable && sample_valid &&
        state_q == rcm_pkg::RCM_RUN && last |=> done)
        else $error("period did not close on its last sample");
    a_unity_gain: assert property (enable && sample_valid && last &&
        state_q == rcm_pkg::RCM_RUN && gain_code == 3'h0 && tot[W] == tot[W-1]
        |=> result == $past(tot[W-1:0]))
        else $error("unity gain result differs from difference");
    a_hi_polarity: assert property (done && over_hi |-> !result[W-1])
        else $error("high flag with negative result");
    a_parity_rev: assert property (done && !reversed |-> !parity)
        else $error("odd parity without any reversal");
endmodule

// *** src/rcm_monitor.sv ***
`timescale 1ns/1ps
module rcm_monitor #(
    parameter int W = 12
) (
    input wire logic CLK,
    input wire logic RST_N,
    input wire logic [7:0] REG_ADDR,
    input wire logic REG_WR,
    input wire logic REG_RD,
    input wire logic [7:0] REG_WDATA,
    output logic [7:0] REG_RDATA,
    input wire logic CH1_SAMPLE_VALID,
    input wire logic [W-1:0] CH1_SAMPLE_TEMP,
    input wire logic CH2_SAMPLE_VALID,
    input wire logic [W-1:0] CH2_SAMPLE_TEMP,
    output logic ALERT_N
);
    // ----------------------------------------------------------------
    // Storage
    // ----------------------------------------------------------------
    logic [7:0] gain_q, gain_d; // Gain codes, both channels
    logic [rcm_pkg::RCM_CFG_WIDTH-1:0] cfg_q, cfg_d; // Enable, masks, hysteresis
    logic [1:0][7:0] lim_hi_q, lim_hi_d; // Limit upper bytes
    logic [1:0][3:0] lim_lo_q, lim_lo_d; // Limit low nibbles
    logic [1:0][3:0] smpl_q, smpl_d; // Sample count codes
    logic [3:0] st_q, st_d; // Sticky high and low flags
    logic [7:0] rdata_d; // Read data next
    logic alert_n_d; // Alert next, active low
    logic rd_status; // Status read in progress
    logic [3:0] ev; // Flag set events this cycle
    logic [3:0] mask4; // Suppress per status bit

    // ----------------------------------------------------------------
    // Channel wiring
    // ----------------------------------------------------------------
    logic [1:0] ch_valid; // Sample strobes
    logic [1:0][W-1:0] ch_temp; // Sample values
    logic [1:0] ch_done; // Period closed, one cycle
    logic [1:0][W-1:0] ch_res; // Latest results
    logic [1:0] ch_rev; // Slope reversed in last period
    logic [1:0] ch_par; // Odd reversal count
    logic [1:0] ch_hi; // Result above limit
    logic [1:0] ch_lo; // Result below negative limit

    assign ch_valid = {CH2_SAMPLE_VALID, CH1_SAMPLE_VALID};
    assign ch_temp = {CH2_SAMPLE_TEMP, CH1_SAMPLE_TEMP};

    // Two identical channels, gain field three bits apart
    for (genvar g = 0; g < 2; g++) begin : g_ch
        rcm_channel #(
            .W(W)
        ) u_ch (
            .clk(CLK),
            .rst_n(RST_N),
            .enable(cfg_q[rcm_pkg::RCM_CFG_EN_BIT]),
            .sample_valid(ch_valid[g]),
            .sample_temp(ch_temp[g]),
            .gain_code(gain_q[rcm_pkg::RCM_GAIN_CH1_LSB + 3*g +: 3]),
            .hyst_code(cfg_q[rcm_pkg::RCM_CFG_HYST_LSB +: 3]),
            .count_code(smpl_q[g]),
            .limit({lim_hi_q[g], lim_lo_q[g]}),
            .done(ch_done[g]),
            .result(ch_res[g]),
            .reversed(ch_rev[g]),
            .parity(ch_par[g]),
            .over_hi(ch_hi[g]),
            .over_lo(ch_lo[g])
        );
    end

    // ----------------------------------------------------------------
    // Register writes, flags and alert
    // ----------------------------------------------------------------
    always_comb begin
        gain_d = gain_q;
        cfg_d = cfg_q;
        lim_hi_d = lim_hi_q;
        lim_lo_d = lim_lo_q;
        smpl_d = smpl_q;
        if (REG_WR) begin
            case (REG_ADDR)
                rcm_pkg::RCM_ADDR_GAIN: gain_d = REG_WDATA;
                // Upper config bits are not stored and read as zero
                rcm_pkg::RCM_ADDR_CONFIG: cfg_d = REG_WDATA[rcm_pkg::RCM_CFG_WIDTH-1:0];
                rcm_pkg::RCM_ADDR_LIM_HI_CH1: lim_hi_d[0] = REG_WDATA;
                rcm_pkg::RCM_ADDR_LIM_HI_CH2: lim_hi_d[1] = REG_WDATA;
                rcm_pkg::RCM_ADDR_LIM_LO_CH1: begin
                    lim_lo_d[0] = REG_WDATA[rcm_pkg::RCM_LIM_LO_LSB +: 4];
                end
                rcm_pkg::RCM_ADDR_LIM_LO_CH2: begin
                    lim_lo_d[1] = REG_WDATA[rcm_pkg::RCM_LIM_LO_LSB +: 4];
                end
                rcm_pkg::RCM_ADDR_SMPL_CH1: smpl_d[0] = REG_WDATA[3:0];
                rcm_pkg::RCM_ADDR_SMPL_CH2: smpl_d[1] = REG_WDATA[3:0];
                // Status, results and unmapped offsets ignore writes
                default: gain_d = gain_q;
            endcase
        end
        rd_status = REG_RD && REG_ADDR == rcm_pkg::RCM_ADDR_STATUS;
        // Events come only when a period closes
        ev = {ch_done[1] & ch_hi[1], ch_done[0] & ch_hi[0],
              ch_done[1] & ch_lo[1], ch_done[0] & ch_lo[0]};
        // Set wins over the read clear so no event is lost
        st_d = (rd_status ? 4'h0 : st_q) | ev;
        mask4 = {cfg_d[rcm_pkg::RCM_CFG_SUP2_BIT], cfg_d[rcm_pkg::RCM_CFG_SUP1_BIT],
                 cfg_d[rcm_pkg::RCM_CFG_SUP2_BIT], cfg_d[rcm_pkg::RCM_CFG_SUP1_BIT]};
        // Alert tracks unsuppressed sticky flags; read drops it
        alert_n_d = !(|(st_d & ~mask4));
    end

    // ----------------------------------------------------------------
    // Read mux, data held until the next read
    // ----------------------------------------------------------------
    always_comb begin
        rdata_d = REG_RDATA;
        if (REG_RD) begin
            case (REG_ADDR)
                rcm_pkg::RCM_ADDR_GAIN: rdata_d = gain_q;
                rcm_pkg::RCM_ADDR_CONFIG: rdata_d = {2'h0, cfg_q};
                rcm_pkg::RCM_ADDR_STATUS: begin
                    rdata_d = {ch_rev[1], ch_rev[0], ch_par[1], ch_par[0], st_q};
                end
                rcm_pkg::RCM_ADDR_RES_HI_CH1: rdata_d = ch_res[0][W-1:W-8];
                rcm_pkg::RCM_ADDR_RES_HI_CH2: rdata_d = ch_res[1][W-1:W-8];
                rcm_pkg::RCM_ADDR_RES_LO: rdata_d = {ch_res[1][3:0], ch_res[0][3:0]};
                rcm_pkg::RCM_ADDR_LIM_HI_CH1: rdata_d = lim_hi_q[0];
                rcm_pkg::RCM_ADDR_LIM_HI_CH2: rdata_d = lim_hi_q[1];
                rcm_pkg::RCM_ADDR_LIM_LO_CH1: rdata_d = {lim_lo_q[0], 4'h0};
                rcm_pkg::RCM_ADDR_LIM_LO_CH2: rdata_d = {lim_lo_q[1], 4'h0};
                rcm_pkg::RCM_ADDR_SMPL_CH1: rdata_d = {4'h0, smpl_q[0]};
                rcm_pkg::RCM_ADDR_SMPL_CH2: rdata_d = {4'h0, smpl_q[1]};
                // Unmapped offsets read as zero
                default: rdata_d = 8'h00;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // Register stage
    // ----------------------------------------------------------------
    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            gain_q <= rcm_pkg::RCM_RST_BYTE;
            cfg_q <= rcm_pkg::RCM_RST_BYTE[rcm_pkg::RCM_CFG_WIDTH-1:0];
            lim_hi_q <= {2{rcm_pkg::RCM_RST_BYTE}};
            lim_lo_q <= {2{rcm_pkg::RCM_RST_BYTE[3:0]}};
            smpl_q <= {2{rcm_pkg::RCM_RST_BYTE[3:0]}};
            st_q <= rcm_pkg::RCM_RST_BYTE[3:0];
            REG_RDATA <= rcm_pkg::RCM_RST_BYTE;
            ALERT_N <= 1'b1;
        end else begin
            gain_q <= gain_d;
            cfg_q <= cfg_d;
            lim_hi_q <= lim_hi_d;
            lim_lo_q <= lim_lo_d;
            smpl_q <= smpl_d;
            st_q <= st_d;
            REG_RDATA <= rdata_d;
            ALERT_N <= alert_n_d;
        end
    end

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RST_N);

    // A channel seeing enable low cannot close a period next edge
    a_disabled_idle: assert property (
        !cfg_q[rcm_pkg::RCM_CFG_EN_BIT] |=> ch_done == 2'b00)
        else $error("period closed while disabled");

    // Unsuppressed flags must show on the pin
    a_ch1_alert: assert property (
        (st_q[rcm_pkg::RCM_ST_HI_CH1] || st_q[rcm_pkg::RCM_ST_LO_CH1]) &&
        !cfg_q[rcm_pkg::RCM_CFG_SUP1_BIT] |-> !ALERT_N)
        else $error("channel 1 flag did not raise alert");

    a_ch2_alert: assert property (
        (st_q[rcm_pkg::RCM_ST_HI_CH1 + 1] || st_q[rcm_pkg::RCM_ST_LO_CH1 + 1]) &&
        !cfg_q[rcm_pkg::RCM_CFG_SUP2_BIT] |-> !ALERT_N)
        else $error("channel 2 flag did not raise alert");

    // Both suppressed: pin must stay released
    a_both_masked: assert property (
        cfg_q[rcm_pkg::RCM_CFG_SUP1_BIT] && cfg_q[rcm_pkg::RCM_CFG_SUP2_BIT]
        |-> ALERT_N)
        else $error("alert driven while both channels suppressed");

    a_hi_set: assert property (
        ch_done[0] && ch_hi[0] |=> st_q[rcm_pkg::RCM_ST_HI_CH1] ##1
        (st_q[rcm_pkg::RCM_ST_HI_CH1] || $past(rd_status)))
        else $error("channel 1 high flag not held");

    a_lo_set: assert property (
        ch_done[1] && ch_lo[1] |=> st_q[rcm_pkg::RCM_ST_LO_CH1 + 1])
        else $error("channel 2 low flag not set");

    a_read_clears: assert property (
        rd_status && !ch_done[0] |=> !st_q[rcm_pkg::RCM_ST_HI_CH1])
        else $error("status read did not clear channel 1 high flag");

    a_status_clear: assert property (
        rd_status && ch_done == 2'b00 |=> st_q == 4'h0)
        else $error("status read did not clear flags");

    a_status_view: assert property (
        rd_status |=> REG_RDATA == {$past(ch_rev), $past(ch_par), $past(st_q)})
        else $error("status read data wrong");

    a_res_hi_read: assert property (
        REG_RD && REG_ADDR == rcm_pkg::RCM_ADDR_RES_HI_CH2
        |=> REG_RDATA == $past(ch_res[1][W-1:W-8]))
        else $error("channel 2 result byte wrong");

    a_res_lo_read: assert property (
        REG_RD && REG_ADDR == rcm_pkg::RCM_ADDR_RES_LO
        |=> REG_RDATA == {$past(ch_res[1][3:0]), $past(ch_res[0][3:0])})
        else $error("shared result nibble byte wrong");

    a_lim_lo_write: assert property (
        REG_WR && REG_ADDR == rcm_pkg::RCM_ADDR_LIM_LO_CH1
        |=> lim_lo_q[0] == $past(REG_WDATA[7:4]))
        else $error("low limit nibble not stored");

    // ----------------------------------------------------------------
    // Register file and flag bookkeeping
    // ----------------------------------------------------------------
    // Writes land at the taking edge, visible one cycle on
    a_lim_lo_ch2: assert property (
        REG_WR && REG_ADDR == rcm_pkg::RCM_ADDR_LIM_LO_CH2
        |=> lim_lo_q[1] == $past(REG_WDATA[7:4]))
        else $error("channel 2 low limit nibble not stored");

    a_cfg_write: assert property (
        REG_WR && REG_ADDR == rcm_pkg::RCM_ADDR_CONFIG
        |=> cfg_q == $past(REG_WDATA[rcm_pkg::RCM_CFG_WIDTH-1:0]))
        else $error("config write not stored");

    a_gain_write: assert property (
        REG_WR && REG_ADDR == rcm_pkg::RCM_ADDR_GAIN |=> gain_q == $past(REG_WDATA))
        else $error("gain write not stored");

    a_smpl_write: assert property (
        REG_WR && REG_ADDR == rcm_pkg::RCM_ADDR_SMPL_CH2
        |=> smpl_q[1] == $past(REG_WDATA[3:0]))
        else $error("sample code write not stored");

    // Sticky flags move only on a period close or a status read
    a_flag_steady: assert property (
        !rd_status && ch_done == 2'b00 |=> st_q == $past(st_q))
        else $error("status flags changed without cause");

    // Each channel's events land in its own bits
    a_hi2_set: assert property (
        ch_done[1] && ch_hi[1] |=> st_q[rcm_pkg::RCM_ST_HI_CH1 + 1])
        else $error("channel 2 high flag not set");

    a_lo1_set: assert property (
        ch_done[0] && ch_lo[0] |=> st_q[rcm_pkg::RCM_ST_LO_CH1])
        else $error("channel 1 low flag not set");

    // With nothing flagged the pin must be released
    a_alert_idle: assert property (
        st_q == 4'h0 |-> ALERT_N)
        else $error("alert driven with no flag set");

    a_res_hi_ch1: assert property (
        REG_RD && REG_ADDR == rcm_pkg::RCM_ADDR_RES_HI_CH1
        |=> REG_RDATA == $past(ch_res[0][W-1:W-8]))
        else $error("channel 1 result byte wrong");

    // Result stands until the channel closes a period
    a_result_hold: assert property (
        ch_done == 2'b00 |-> ch_res == $past(ch_res))
        else $error("result changed without period close");

    // Main scenarios worth seeing in coverage

    c_ch1_high: cover property (ch_done[0] && ch_hi[0]);
    c_ch2_low: cover property (ch_done[1] && ch_lo[1]);
    c_alert_read: cover property (!ALERT_N ##1 rd_status ##1 ALERT_N);
    c_reversal: cover property (ch_done[0] && ch_rev[0] && ch_par[0]);
    c_both_flagged: cover property (st_q[rcm_pkg::RCM_ST_HI_CH1] && st_q[rcm_pkg::RCM_ST_LO_CH1 + 1]);
endmodule

// *** bench/rcm_host.sv ***
`timescale 1ns/1ps
// Host side: one register access per call, one-cycle strobes
module rcm_host (
    input wire logic clk,
    input wire logic [7:0] rdata,
    output logic [7:0] addr,
    output logic wr,
    output logic rd,
    output logic [7:0] wdata
);
    // Idle bus parks off the map, so a stale offset cannot pass
    initial {wr, rd, addr, wdata} = {2'b00, 8'hff, 8'h00};
    // Taken at the second edge; read data is settled just after it
    task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d,
            output logic [7:0] r);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= w;
        rd <= ~w;
        @(posedge clk);
        {wr, rd} <= 2'b00;
        addr <= 8'hff;
        wdata <= ~d;
        #1 r = rdata;
    endtask
endmodule

// *** bench/rcm_monitor_tb.sv ***
`timescale 1ns/1ps
// ----------------
// Scenario bench
// ----------------
module rcm_monitor_tb;
    logic clk = 1'b0, rst_n = 1'b0;
    logic [7:0] addr, wdata, rdata, q;
    logic wr, rd, alert_n, v1 = 1'b0, v2 = 1'b0;
    logic [11:0] t1 = 12'h000, t2 = 12'h000;
    int failures = 0, n_checks = 0;
    rcm_monitor u_rcm_monitor (.CLK(clk), .RST_N(rst_n), .REG_ADDR(addr), .REG_WR(wr),
        .REG_RD(rd), .REG_WDATA(wdata), .REG_RDATA(rdata), .CH1_SAMPLE_VALID(v1),
        .CH1_SAMPLE_TEMP(t1), .CH2_SAMPLE_VALID(v2), .CH2_SAMPLE_TEMP(t2),
        .ALERT_N(alert_n));
    rcm_host u_rcm_host (.clk(clk), .rdata(rdata), .addr(addr), .wr(wr), .rd(rd),
        .wdata(wdata));
    // 8 ns period
    initial forever #4 clk = ~clk;
    // Hang guard; the tests need under two thousand cycles
    initial begin
        repeat (4000) @(posedge clk);
        failures++;
        summarize();
    end
    task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
        n_checks++;
        if (g !== e) begin
            failures++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic put(input logic [7:0] a, input logic [7:0] d);
        u_rcm_host.xfer(1'b1, a, d, q);
    endtask
    task automatic rchk(input logic [7:0] a, input logic [7:0] e);
        u_rcm_host.xfer(1'b0, a, 8'h00, q);
        chk($sformatf("reg %h", a), e, q);
    endtask
    // Both channels sample together; idle temps invert, then flag latency passes
    task automatic smp(input logic [11:0] a, input logic [11:0] b);
        @(posedge clk);
        {v2, v1, t2, t1} <= {2'b11, b, a};
        @(posedge clk);
        {v2, v1, t2, t1} <= {2'b00, ~b, ~a};
        repeat (3) @(negedge clk);
    endtask
    // Reset values, including the unmapped gap above the block
    task automatic t_idle();
        for (int i = 8'h3d; i < 8'h50; i++) rchk(i[7:0], 8'h00);
        $display("idle test done");
    endtask
    // Stored widths and read-only places; limits of five left behind
    task automatic t_access();
        logic [7:0] a [6] = '{8'h3d, 8'h3e, 8'h42, 8'h47, 8'h48, 8'h3f};
        logic [7:0] e [6] = '{8'hff, 8'h3f, 8'hf0, 8'hf0, 8'h0f, 8'h00};
        for (int i = 0; i < 6; i++) begin
            put(a[i], 8'hff);
            rchk(a[i], e[i]);
            put(a[i], a[i] > 8'h41 ? 8'h50 : 8'h00);
        end
        $display("access test done");
    endtask
    // One row per case: gain, config, closing temps, alert, results, flags
    task automatic t_alert();
        logic [7:0] g [6] = '{8'h00, 8'h00, 8'h11, 8'h00, 8'h00, 8'h00};
        logic [7:0] c [6] = '{8'h00, 8'h20, 8'h20, 8'h28, 8'h30, 8'h30};
        logic [11:0] a [6] = '{12'h1ff, 12'h113, 12'h0fe, 12'h120, 12'h100, 12'h120};
        logic [11:0] b [6] = '{12'h1ff, 12'h105, 12'h0fe, 12'h100, 12'h0e0, 12'h0e0};
        logic [5:0] ea = 6'b011001;
        logic [7:0] eh [6] = '{8'h00, 8'h01, 8'hff, 8'h02, 8'h00, 8'h02};
        logic [7:0] el [6] = '{8'h00, 8'h53, 8'h8c, 8'h00, 8'h00, 8'h00};
        logic [7:0] es [6] = '{8'h00, 8'h04, 8'h02, 8'h04, 8'h02, 8'h06};
        for (int i = 0; i < 6; i++) begin
            put(8'h3d, g[i]);
            put(8'h3e, 8'h00);
            put(8'h3e, c[i]);
            smp(12'h100, 12'h100);
            smp(a[i], b[i]);
            chk("alert", {7'h00, ea[i]}, {7'h00, alert_n});
            rchk(8'h40, eh[i]);
            rchk(8'h45, el[i]);
            rchk(8'h3f, es[i]);
            chk("alert released", 8'h01, {7'h00, alert_n});
        end
        $display("alert test done");
    endtask
    // Three-sample periods; an 8-step swing against hysteresis 4, then 8
    task automatic t_rev();
        put(8'h43, 8'h01);
        put(8'h48, 8'h01);
        for (int j = 3; j < 5; j++) begin
            put(8'h3e, 8'h00);
            put(8'h3e, 8'h20 | j[7:0]);
            smp(12'h100, 12'h100);
            smp(12'h108, 12'h104);
            rchk(8'h40, j == 3 ? 8'h02 : 8'h00);
            smp(12'h100, 12'h108);
            rchk(8'h40, 8'h00);
            rchk(8'h3f, j == 3 ? 8'h58 : 8'h08);
        end
        $display("reversal test done");
    endtask
    // Longest period: code 0xf closes on the 257th sample only
    task automatic t_long();
        put(8'h43, 8'h0f);
        rchk(8'h43, 8'h0f);
        put(8'h3e, 8'h00);
        put(8'h3e, 8'h20);
        smp(12'h100, 12'h100);
        repeat (255) smp(12'h101, 12'h100);
        rchk(8'h45, 8'h00);
        smp(12'h110, 12'h100);
        rchk(8'h40, 8'h01);
        $display("long period test done");
    endtask
    task automatic summarize();
        $display("checks %0d failures %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    // Reset held twelve cycles, then the scenarios in turn
    initial begin
        repeat (12) @(posedge clk);
        rst_n <= 1'b1;
        t_idle();
        t_access();
        t_alert();
        t_rev();
        t_long();
        summarize();
    end
endmodule
